// ==== verification/spcr_cpu_model.sv ====
// CPU core model issuing load and store strobes
// Assumes tasks are called just after a rising edge
`timescale 1ns/1ps
module spcr_cpu_model (
  input wire clk,
  output reg load_strobe,
  output reg store_strobe,
  output reg [15:0] load_z,
  output wire [15:0] flash_word
);
  assign flash_word = 16'hC35A;
  initial begin
    load_strobe = 1'b0;
    store_strobe = 1'b0;
    load_z = 16'h0000;
  end
  // One load, Z released to its inverse
  task ld(input [15:0] z);
    begin
      load_z <= z;
      load_strobe <= 1'b1;
      @(posedge clk);
      load_strobe <= 1'b0;
      load_z <= ~z;
    end
  endtask
  // One store-to-program
  task st;
    begin
      store_strobe <= 1'b1;
      @(posedge clk);
      store_strobe <= 1'b0;
    end
  endtask
endmodule // spcr_cpu_model

// ==== verification/spcr_properties.sv ====
// Port checker for the config readout block
// Assumes one clock, reset active high
`timescale 1ns/1ps
`include "spcr_defines.vh"
module spcr_properties (
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire eeprom_write_busy,
  input wire load_strobe,
  input wire store_strobe,
  input wire load_valid,
  input wire prog_busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_ee_long;
    eeprom_write_busy [*8] ##1 eeprom_write_busy [*2];
  endsequence
  sequence s_fuse_setup;
    psel && !penable && !pwrite && paddr == `SPCR_FUSE_OFF;
  endsequence
  chk_apb_answer: assert property (psel && !penable |=> pready) else $error("no ready");
  chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  chk_load_answer: assert property (load_strobe |=> load_valid) else $error("no load answer");
  chk_load_cause: assert property (load_valid |-> $past(load_strobe)) else $error("stray answer");
  chk_fuse_hidden: assert property (s_ee_long ##0 s_fuse_setup |=> prdata == 32'h0)
    else $error("fuse shown");
  chk_prog_blocked: assert property (s_ee_long ##0 store_strobe |=> !$rose(prog_busy) [*3])
    else $error("prog ran");
  chk_prog_cause: assert property ($rose(prog_busy) |-> $past(store_strobe, 2) ||
    $past(store_strobe, 3) || $past(reset) || $past(reset, 2)) else $error("prog uncaused");
  chk_prog_hold: assert property ($rose(prog_busy) |-> prog_busy [*8]) else $error("prog short");
endmodule // spcr_properties
bind spcr_top spcr_properties u_chk (.*);

// ==== verification/testbench.sv ====
// Self-checking bench for the config readout block
// Assumes the CPU model drives load and store strobes
`timescale 1ns/1ps
`include "spcr_defines.vh"
module testbench;
  localparam [39:0] lk = 40'hFF6EF93CA5;
  localparam [111:0] zs = 112'h03171615131211100F0E04020100;
  localparam [111:0] sv = 112'hFF998877556633441122A3A25CA1;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg eeprom_write_busy = 1'b0;
  wire [7:0] fuse_low_byte = 8'hA5;
  wire [7:0] fuse_high_byte = 8'h6E;
  wire [7:0] fuse_extended_byte = 8'hF9;
  wire [7:0] lock_bits = 8'h3C;
  reg [7:0] osc_cal_byte = 8'h5C;
  wire [31:0] prdata;
  wire pready, pslverr, load_strobe, store_strobe, load_valid, prog_busy;
  wire [15:0] load_z, flash_word, flash_addr;
  wire [7:0] load_data;
  wire [1:0] prog_op;
  reg [31:0] rd;
  reg err;
  integer n_fail = 0;
  integer checks = 0;
  integer cyc = 0;
  integer i;
  integer n;
  spcr_top #(.PROG_CYCLES(20), .SIG_BYTE0(8'hA1), .SIG_BYTE1(8'hA2), .SIG_BYTE2(8'hA3),
    .SERIAL(72'h998877665544332211)) DUT (.*);
  spcr_cpu_model cpu (.*);
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail = n_fail + 1;
      wrap_up;
    end
  end
  task wrap_up;
    begin
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task ctl(input [7:0] v);
    apb(1'b1, `SPCR_CTRL_OFF, {24'h0, v});
  endtask
  task rdld(input [15:0] z, input [7:0] e);
    begin
      cpu.ld(z);
      @(posedge clk);
      chk(load_valid, 1);
      chk(load_data, e);
    end
  endtask
  task prog(input [7:0] c, input [1:0] o);
    begin
      ctl(c);
      cpu.st;
      while (prog_busy !== 1'b1)
        @(posedge clk);
      chk(prog_op, o);
      n = 0;
      while (prog_busy === 1'b1) begin
        @(posedge clk);
        n = n + 1;
      end
      chk(n >= 20 && n <= 21, 1);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    apb(1'b1, `SPCR_STAT_OFF, 32'h0);
    chk(err, 1);
    apb(1'b0, `SPCR_FUSE_OFF, 32'h0);
    chk(rd, 32'h00F96EA5);
    for (i = 0; i < 5; i = i + 1) begin
      ctl(8'h09);
      rdld(i[15:0], lk[8*i +: 8]);
    end
    for (i = 0; i < 14; i = i + 1) begin
      ctl(8'h21);
      rdld({8'h00, zs[8*i +: 8]}, sv[8*i +: 8]);
    end
    ctl(8'h09);
    rdld(16'h0001, 8'h3C);
    rdld(16'h0001, 8'hC3);
    osc_cal_byte <= 8'h3A;
    ctl(8'h21);
    rdld(16'h0001, 8'h3A);
    ctl(8'h21);
    repeat (3) @(posedge clk);
    rdld(16'h0020, 8'h5A);
    chk(flash_addr, 16'h0010);
    prog(8'h03, 2'd1);
    apb(1'b0, `SPCR_STAT_OFF, 32'h0);
    chk(rd[0], 1);
    prog(8'h05, 2'd2);
    prog(8'h09, 2'd3);
    apb(1'b0, `SPCR_STAT_OFF, 32'h0);
    chk(rd[0], 1);
    ctl(8'h11);
    cpu.st;
    apb(1'b0, `SPCR_STAT_OFF, 32'h0);
    chk(rd[0], 0);
    ctl(8'h03);
    repeat (4) @(posedge clk);
    cpu.st;
    repeat (3) @(posedge clk);
    chk(prog_busy, 0);
    ctl(8'h05);
    cpu.st;
    repeat (6) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk(prog_busy, 1);
    while (prog_busy === 1'b1)
      @(posedge clk);
    eeprom_write_busy <= 1'b1;
    repeat (8) @(posedge clk);
    ctl(8'h09);
    rdld(16'h0000, 8'h5A);
    apb(1'b0, `SPCR_FUSE_OFF, 32'h0);
    chk(rd, 32'h0);
    ctl(8'h03);
    cpu.st;
    repeat (3) @(posedge clk);
    chk(prog_busy, 0);
    eeprom_write_busy <= 1'b0; // Busy cleared after the blocked-store check, just before wrap_up
    wrap_up;
  end
endmodule // testbench

// ==== verilog/spcr_defines.vh ====
// Constants for the self-programming configuration readout block
// Assumes a 10 MHz core clock and byte-wide control register
`ifndef SPCR_DEFINES_VH
`define SPCR_DEFINES_VH
// Register APB offsets and control register bit positions
`define SPCR_CTRL_OFF 12'h000
`define SPCR_STAT_OFF 12'h004
`define SPCR_ZPTR_OFF 12'h008
`define SPCR_FUSE_OFF 12'h00C
`define SPCR_LOCK_OFF 12'h010
`define SPCR_BIT_OPEN 0
`define SPCR_BIT_ERASE 1
`define SPCR_BIT_WRITE 2
`define SPCR_BIT_LOCK 3
`define SPCR_BIT_REEN 4
`define SPCR_BIT_SIG 5
`define SPCR_BIT_BUSY 6
// Z-pointer addresses
`define SPCR_Z_FLB 16'h0000
`define SPCR_Z_LOCK 16'h0001
`define SPCR_Z_EFB 16'h0002
`define SPCR_Z_FHB 16'h0003
`define SPCR_Z_SIG0 16'h0000
`define SPCR_Z_CAL 16'h0001
`define SPCR_Z_SIG1 16'h0002
`define SPCR_Z_SIG2 16'h0004
`define SPCR_Z_SN1 16'h000E
`define SPCR_Z_SN0 16'h000F
`define SPCR_Z_SN3 16'h0010
`define SPCR_Z_SN2 16'h0011
`define SPCR_Z_SN5 16'h0012
`define SPCR_Z_SN4 16'h0013
`define SPCR_Z_SN6 16'h0015
`define SPCR_Z_SN7 16'h0016
`define SPCR_Z_SN8 16'h0017
// Arming windows in CPU cycles
`define SPCR_LOAD_WIN 3
`define SPCR_STORE_WIN 4
// Programming time, 10 MHz clock
`define SPCR_CLK_KHZ 10000
`define SPCR_PROG_MIN_US 3200
`define SPCR_PROG_MAX_US 3400
`define SPCR_PROG_CYC ((`SPCR_PROG_MIN_US * `SPCR_CLK_KHZ + 999) / 1000)
`endif

// ==== verilog/spcr_prog_timer.v ====
// Flash programming timer, counts one operation length
// Assumes it is clocked from the calibrated oscillator domain clock
`timescale 1ns/1ps
`include "spcr_defines.vh"
module spcr_prog_timer #(
  parameter CYCLES = `SPCR_PROG_CYC
) (
  input wire clk,
  input wire start,
  input wire hold_reset,
  output reg busy,
  output reg done
);
  reg [31:0] count;
  // No async reset: a running write survives reset
  initial begin
    busy = 1'b0;
    done = 1'b0;
    count = 32'h00000000;
  end
  always @(posedge clk) begin
    done <= 1'b0;
    if (busy) begin
      if (count == CYCLES - 1) begin
        busy <= 1'b0;
        done <= 1'b1;
        count <= 32'h00000000;
      end else begin
        count <= count + 32'h00000001;
      end
    end else if (start && !hold_reset) begin
      busy <= 1'b1;
      count <= 32'h00000000;
    end
  end
endmodule // spcr_prog_timer

// ==== verilog/spcr_sync.v ====
// Three-stage synchroniser with second/third agreement
// Assumes an asynchronous level input
`timescale 1ns/1ps
module spcr_sync (
  input wire clk,
  input wire reset,
  input wire din,
  output reg dout
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule // spcr_sync

// ==== verilog/spcr_top.v ====
// Self-programming config readout, APB register slave
// Assumes CPU issues load/store strobes on clk; EEPROM busy is a pin
`timescale 1ns/1ps
`include "spcr_defines.vh"

// What this block does
// - EEPROM write blocks all flash programming
// - EEPROM write blocks fuse and lock reads
// - Lock read at Z 0001 within three cycles
// - Lock mode self-clears on read or timeout
// - Disarmed load does ordinary flash read
// - Z 0000 returns low fuse byte
// - Z 0003 returns high fuse byte
// - Z 0002 returns extended fuse byte
// - Programmed reads zero, unprogrammed reads one
// - Signature read within three cycles
// - Signature mode self-clears on read or timeout
// - Device id bytes at 0000, 0002, 0004
// - Calibration byte at Z 0001
// - Serial number bytes at fixed addresses
// - Running write completes across reset
// - Erase and write last 3.2 to 3.4ms
// - Store must follow within four cycles
// - Busy flag held until re-enable written
// - Z bit 0 selects byte in word
module spcr_top #(
  parameter PROG_CYCLES = `SPCR_PROG_CYC,
  parameter [7:0] SIG_BYTE0 = 8'h11,
  parameter [7:0] SIG_BYTE1 = 8'h22,
  parameter [7:0] SIG_BYTE2 = 8'h33,
  parameter [71:0] SERIAL = 72'h0
) (
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire eeprom_write_busy,
  input wire load_strobe,
  input wire store_strobe,
  input wire [15:0] load_z,
  input wire [15:0] flash_word,
  input wire [7:0] fuse_low_byte,
  input wire [7:0] fuse_high_byte,
  input wire [7:0] fuse_extended_byte,
  input wire [7:0] lock_bits,
  input wire [7:0] osc_cal_byte,
  output reg [15:0] flash_addr,
  output reg [7:0] load_data,
  output reg load_valid,
  output reg prog_busy,
  output reg [1:0] prog_op
);
  localparam ST_IDLE = 3'b001;
  localparam ST_ARM = 3'b010;
  localparam ST_PROG = 3'b100;

  reg [2:0] state;
  reg [6:0] ctrl;
  reg [2:0] win;
  reg app_busy;
  wire ee_busy;
  wire tmr_busy;
  wire tmr_done;
  reg tmr_start;
  wire apb_wr;
  wire apb_rd;
  wire lock_mode;
  wire sig_mode;

  function [7:0] sig_lookup;
    input [15:0] z;
    begin
      case (z)
        `SPCR_Z_SIG0: sig_lookup = SIG_BYTE0;
        `SPCR_Z_CAL: sig_lookup = osc_cal_byte;
        `SPCR_Z_SIG1: sig_lookup = SIG_BYTE1;
        `SPCR_Z_SIG2: sig_lookup = SIG_BYTE2;
        `SPCR_Z_SN0: sig_lookup = SERIAL[7:0];
        `SPCR_Z_SN1: sig_lookup = SERIAL[15:8];
        `SPCR_Z_SN2: sig_lookup = SERIAL[23:16];
        `SPCR_Z_SN3: sig_lookup = SERIAL[31:24];
        `SPCR_Z_SN4: sig_lookup = SERIAL[39:32];
        `SPCR_Z_SN5: sig_lookup = SERIAL[47:40];
        `SPCR_Z_SN6: sig_lookup = SERIAL[55:48];
        `SPCR_Z_SN7: sig_lookup = SERIAL[63:56];
        `SPCR_Z_SN8: sig_lookup = SERIAL[71:64];
        default: sig_lookup = 8'hFF;
      endcase
    end
  endfunction

  function [7:0] fuse_lookup;
    input [15:0] z;
    begin
      // Stored values already use programmed = 0
      case (z)
        `SPCR_Z_FLB: fuse_lookup = fuse_low_byte;
        `SPCR_Z_LOCK: fuse_lookup = lock_bits;
        `SPCR_Z_EFB: fuse_lookup = fuse_extended_byte;
        `SPCR_Z_FHB: fuse_lookup = fuse_high_byte;
        default: fuse_lookup = 8'hFF;
      endcase
    end
  endfunction

  spcr_sync u_ee_sync (
    .clk(clk),
    .reset(reset),
    .din(eeprom_write_busy),
    .dout(ee_busy)
  );

  spcr_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .clk(clk),
    .start(tmr_start),
    .hold_reset(reset),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign lock_mode = ctrl[`SPCR_BIT_OPEN] && ctrl[`SPCR_BIT_LOCK];
  assign sig_mode = ctrl[`SPCR_BIT_OPEN] && ctrl[`SPCR_BIT_SIG];

  // Control state machine
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      ctrl <= 7'h00;
      win <= 3'h0;
      app_busy <= 1'b0;
      tmr_start <= 1'b0;
      prog_op <= 2'h0;
      load_data <= 8'h00;
      load_valid <= 1'b0;
      flash_addr <= 16'h0000;
    end else begin
      tmr_start <= 1'b0;
      load_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (apb_wr && paddr == `SPCR_CTRL_OFF && pwdata[`SPCR_BIT_OPEN] && !ee_busy) begin
            ctrl <= pwdata[6:0] & 7'h3F;
            win <= 3'h0;
            state <= ST_ARM;
          end
          if (load_strobe) begin
            flash_addr <= {1'b0, load_z[15:1]};
            load_data <= load_z[0] ? flash_word[15:8] : flash_word[7:0];
            load_valid <= 1'b1;
          end
        end
        ST_ARM: begin
          win <= win + 3'h1;
          if (load_strobe && (lock_mode || sig_mode) && win < `SPCR_LOAD_WIN) begin
            load_data <= sig_mode ? sig_lookup(load_z) : fuse_lookup(load_z);
            load_valid <= 1'b1;
            ctrl <= 7'h00;
            state <= ST_IDLE;
          end else if (store_strobe && win < `SPCR_STORE_WIN && !sig_mode) begin
            if (ctrl[`SPCR_BIT_REEN]) begin
              app_busy <= 1'b0;
              ctrl <= 7'h00;
              state <= ST_IDLE;
            end else if (ctrl[`SPCR_BIT_ERASE] || ctrl[`SPCR_BIT_WRITE] || ctrl[`SPCR_BIT_LOCK]) begin
              tmr_start <= 1'b1;
              prog_op <= ctrl[`SPCR_BIT_LOCK] ? 2'h3 : (ctrl[`SPCR_BIT_WRITE] ? 2'h2 : 2'h1);
              if (!ctrl[`SPCR_BIT_LOCK]) begin
                app_busy <= 1'b1;
              end
              state <= ST_PROG;
            end else begin
              ctrl <= 7'h00;
              state <= ST_IDLE;
            end
          end else if ((sig_mode && win >= `SPCR_LOAD_WIN - 1) || win >= `SPCR_STORE_WIN - 1) begin
            ctrl <= 7'h00;
            state <= ST_IDLE;
          end
        end
        ST_PROG: begin
          if (tmr_done) begin
            ctrl <= 7'h00;
            prog_op <= 2'h0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Busy output straight from a flop
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      prog_busy <= 1'b0;
    end else begin
      prog_busy <= tmr_busy || tmr_start;
    end
  end

  // APB slave, one wait-free access cycle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h00000000;
        case (paddr)
          `SPCR_CTRL_OFF: prdata <= {25'h0, app_busy, ctrl[5:0]};
          `SPCR_STAT_OFF: prdata <= {29'h0, ee_busy, tmr_busy, app_busy};
          `SPCR_ZPTR_OFF: prdata <= {16'h0, flash_addr};
          `SPCR_FUSE_OFF: prdata <= ee_busy ? 32'h00000000 : {8'h0, fuse_extended_byte, fuse_high_byte, fuse_low_byte};
          `SPCR_LOCK_OFF: prdata <= ee_busy ? 32'h00000000 : {24'h0, lock_bits};
          default: pslverr <= 1'b1;
        endcase
        if (!pwrite) begin
          pslverr <= !(paddr == `SPCR_CTRL_OFF || paddr == `SPCR_STAT_OFF || paddr == `SPCR_ZPTR_OFF ||
                       paddr == `SPCR_FUSE_OFF || paddr == `SPCR_LOCK_OFF);
        end else begin
          pslverr <= paddr != `SPCR_CTRL_OFF;
        end
      end
    end
  end
endmodule // spcr_top
